// file: verilog/result_port_params.svh
/*
 * Constants for the parallel result read-out port: select codes,
 * control word fields, tag word layout and result storage sizes.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef RESULT_PORT_PARAMS_SVH
`define RESULT_PORT_PARAMS_SVH

`define NUM_CHANNELS      6
`define RESULTS_PER_CHAN  3
`define STORE_DEPTH       18
`define STORE_IDX_W       5
`define SEL_CYCLE         3'h6
`define SEL_FIFO          3'h7
`define CW_MODE_BIT       7
`define CW_TAG_EN_BIT     3
`define CW_RESET_BIT      3
`define TAG_WORD_HEAD     12'h800
`define LAST_DIRECT_CHAN  3'h5

`endif

// file: verilog/result_port_pkg.sv
/*
 * Types shared by the result read-out port modules.
 * Assumes the constants header is available on the include path.
 */
package result_port_pkg;
   typedef enum logic [2:0]
   {
      PH_FIRST  = 3'b001,
      PH_SECOND = 3'b010,
      PH_THIRD  = 3'b100
   } read_phase_t;

   typedef struct packed
   {
      logic [2:0]  chan;
      logic [15:0] data;
   } result_entry_t;
endpackage

// file: verilog/pin_sync.sv
/*
 * Two-stage synchroniser for a group of asynchronous pins.
 * Assumes inputs come from pins outside the core clock domain.
 */
`timescale 1ns/1ps
module pin_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // pin_sync

// file: verilog/result_store.sv
/*
 * Shift-down result store: new results land in the lowest free entry,
 * a finished head read drops entry 0, and a full store loses its oldest.
 * Assumes push and pop are one-cycle pulses on core_clk.
 */
`timescale 1ns/1ps
`include "result_port_params.svh"
module result_store
(
   input  wire logic                                core_clk,
   input  wire logic                                rstn,
   input  wire logic                                push,
   input  wire result_port_pkg::result_entry_t      push_entry,
   input  wire logic                                pop,
   output result_port_pkg::result_entry_t           head,
   output logic                                     empty,
   output logic [`STORE_IDX_W-1:0]                  count
);
   result_port_pkg::result_entry_t mem [`STORE_DEPTH];
   logic                           full;
   logic                           shift;
   logic [`STORE_IDX_W-1:0]        wr_idx;
   logic [`STORE_IDX_W-1:0]        next_count;

   // Shift when reading the head or when dropping the oldest when full
   assign full   = (count == `STORE_IDX_W'(`STORE_DEPTH));
   assign shift  = pop && !empty || push && full;
   assign wr_idx = shift ? count - `STORE_IDX_W'(1) : count;
   assign empty  = (count == '0);
   assign head   = mem[0];
   assign next_count = push ? (shift ? count : count + 1'b1)
                            : (shift ? count - 1'b1 : count);

   // Per-entry shift and write
   genvar i;
   generate
      for (i = 0; i < `STORE_DEPTH; i++)
      begin : g_entry
         always_ff @(posedge core_clk)
         begin
            if (!rstn)
               mem[i] <= '0;
            else if (push && wr_idx == `STORE_IDX_W'(i))
               mem[i] <= push_entry;
            else if (shift && i < `STORE_DEPTH - 1)
               mem[i] <= mem[(i + 1) % `STORE_DEPTH];
         end
      end
   endgenerate

   // Entry count
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         count <= '0;
      else
         count <= next_count;
   end

   a_full_drops_oldest:
      assert property (@(posedge core_clk) disable iff (!rstn)
      push && full && !pop |=> count == `STORE_IDX_W'(`STORE_DEPTH))
      else $error("full store did not stay full after push");
   a_push_grows:
      assert property (@(posedge core_clk) disable iff (!rstn)
      push && !pop && !full |=> count == $past(count) + 1'b1)
      else $error("push into free store did not add one entry");
   a_pop_shrinks:
      assert property (@(posedge core_clk) disable iff (!rstn)
      pop && !push && !empty |=> count == $past(count) - 1'b1)
      else $error("head read did not remove one entry");
   c_store_full: cover property (@(posedge core_clk) disable iff (!rstn)
      full && push);
endmodule // result_store

// file: verilog/result_read_port.sv
/*
 * Parallel result read-out port of a six-channel converter: direct,
 * cycle and result-store modes, tagged and byte-wide reads, and the
 * 8-bit control word written over the data bus.
 * Assumes results arrive as one-cycle strobes from conversion logic on
 * core_clk, and host pins are asynchronous and pass two flip-flops.
 */
`timescale 1ns/1ps
`include "result_port_params.svh"
module result_read_port
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic        chan_sel_bit0,
   input  wire logic        chan_sel_bit1,
   input  wire logic        chan_sel_bit2,
   input  wire logic        tag_en,
   input  wire logic        byte_mode,
   input  wire logic        reset_pin,
   input  wire logic [15:0] parallel_data_bus_in,
   input  wire logic [5:0]  result_valid,
   input  wire logic [95:0] result_data,
   output logic [15:0]      parallel_data_bus_out,
   output logic             parallel_data_bus_oe,
   output logic             soft_reset,
   output logic             sample_hold_pair_first,
   output logic             sample_hold_pair_second,
   output logic             sample_hold_pair_third,
   output logic             first_data_ready
);
   // Synchronised host pins; strobes enter inverted so reset reads as idle
   logic [22:0] pins_async;
   logic [22:0] pins_sync;
   logic        s_cs_n;
   logic        s_rd_n;
   logic        s_wr_n;
   logic [2:0]  s_sel;
   logic        s_tag_en;
   logic        s_byte;
   logic        s_reset_pin;
   logic [15:0] s_bus;

   assign pins_async = {!cs_n, !rd_n, !wr_n, chan_sel_bit2, chan_sel_bit1,
                        chan_sel_bit0, tag_en, byte_mode, reset_pin,
                        parallel_data_bus_in[15:2]};

   pin_sync #(.WIDTH(23)) u_sync
   (
      .core_clk (core_clk),
      .rstn     (rstn),
      .async_in (pins_async),
      .sync_out (pins_sync)
   );

   // The bus low bits are only needed on control writes, sync them too
   logic [1:0]  bus_lo_s1;
   logic [1:0]  bus_lo_s2;
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         bus_lo_s1 <= '0;
         bus_lo_s2 <= '0;
      end
      else
      begin
         bus_lo_s1 <= parallel_data_bus_in[1:0];
         bus_lo_s2 <= bus_lo_s1;
      end
   end

   assign s_cs_n      = !pins_sync[22];
   assign s_rd_n      = !pins_sync[21];
   assign s_wr_n      = !pins_sync[20];
   assign s_sel       = pins_sync[19:17];
   assign s_tag_en    = pins_sync[16];
   assign s_byte      = pins_sync[15];
   assign s_reset_pin = pins_sync[14];
   assign s_bus       = {pins_sync[13:0], bus_lo_s2};

   // Control word configuration bits and edges of the strobes
   logic [3:0]  cfg_word;
   logic        rd_low_d;
   logic        wr_low_d;
   logic        rd_low;
   logic        rd_rise;
   logic        wr_rise;
   logic        cw_config;
   logic        cw_cmd;
   logic [2:0]  sel;
   logic        tag_on;
   logic        direct;
   logic        any_reset;

   assign rd_low    = !s_cs_n && !s_rd_n;
   assign rd_rise   = rd_low_d && !rd_low;
   assign wr_rise   = wr_low_d && !(!s_cs_n && !s_wr_n);
   assign cw_config = wr_rise && s_bus[`CW_MODE_BIT];
   assign cw_cmd    = wr_rise && !s_bus[`CW_MODE_BIT];
   assign sel       = s_sel | cfg_word[2:0];
   assign direct    = (sel <= `LAST_DIRECT_CHAN);
   assign tag_on    = (s_tag_en | cfg_word[`CW_TAG_EN_BIT]) && !direct;
   assign any_reset = s_reset_pin | (cw_cmd && s_bus[`CW_RESET_BIT]);

   // Strobe edge history and control word latch
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         rd_low_d <= 1'b0;
         wr_low_d <= 1'b0;
         cfg_word <= '0;
      end
      else
      begin
         rd_low_d <= rd_low;
         wr_low_d <= !s_cs_n && !s_wr_n;
         if (cw_config)
            cfg_word <= s_bus[3:0];
      end
   end

   // Command word outputs: one-cycle pulses; soft_reset also stays high while the reset pin is high
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         soft_reset              <= 1'b0;
         sample_hold_pair_first  <= 1'b0;
         sample_hold_pair_second <= 1'b0;
         sample_hold_pair_third  <= 1'b0;
      end
      else
      begin
         soft_reset              <= any_reset;
         sample_hold_pair_first  <= cw_cmd && s_bus[2];
         sample_hold_pair_second <= cw_cmd && s_bus[1];
         sample_hold_pair_third  <= cw_cmd && s_bus[0];
      end
   end

   // Latest result per channel and pending store pushes
   logic [15:0] chan_reg [`NUM_CHANNELS];
   logic [15:0] pend_data [`NUM_CHANNELS];
   logic [5:0]  pending;
   logic [2:0]  pend_idx;
   logic        pend_any;

   genvar c;
   generate
      for (c = 0; c < `NUM_CHANNELS; c++)
      begin : g_chan
         always_ff @(posedge core_clk)
         begin
            if (!rstn || any_reset)
               chan_reg[c] <= '0;
            else if (pending[c] && !rd_low)
               chan_reg[c] <= pend_data[c];
         end
      end
   endgenerate

   // Lowest pending channel goes to the store first
   always_comb
   begin
      pend_idx = '0;
      for (int k = `NUM_CHANNELS - 1; k >= 0; k--)
         if (pending[k])
            pend_idx = 3'(k);
   end
   assign pend_any = |pending;

   // Results arriving during a read wait until the strobe rises
   logic [5:0] next_pending;
   logic       push;
   logic       pop;
   assign push = pend_any && !rd_low;
   always_comb
   begin
      next_pending = pending | result_valid;
      if (push)
         next_pending[pend_idx] = result_valid[pend_idx];
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn || any_reset)
         pending <= '0;
      else
         pending <= next_pending;
   end

   // Captured values for pending channels: a newer result on the channel overwrites during wait
   generate
      for (c = 0; c < `NUM_CHANNELS; c++)
      begin : g_pend
         always_ff @(posedge core_clk)
         begin
            if (!rstn)
               pend_data[c] <= '0;
            else if (result_valid[c])
               pend_data[c] <= result_data[16*c +: 16];
         end
      end
   endgenerate

   result_port_pkg::result_entry_t head;
   result_port_pkg::result_entry_t push_entry;
   logic                           empty;
   logic                           store_rstn;
   assign push_entry = '{chan: pend_idx, data: pend_data[pend_idx]};
   assign store_rstn = rstn && !any_reset;

   result_store u_store
   (
      .core_clk   (core_clk),
      .rstn       (store_rstn),
      .push       (push),
      .push_entry (push_entry),
      .pop        (pop),
      .head       (head),
      .empty      (empty),
      .count      ()
   );

   // Read phase counter and cycle pointer
   result_port_pkg::read_phase_t phase;
   result_port_pkg::read_phase_t next_phase;
   logic [2:0]                   cyc_chan;
   logic                         last_word;

   always_comb
   begin
      unique case (phase)
         result_port_pkg::PH_FIRST:  last_word = !tag_on && !s_byte;
         result_port_pkg::PH_SECOND: last_word = !(tag_on && s_byte);
         result_port_pkg::PH_THIRD:  last_word = 1'b1;
         default:                    last_word = 1'b1;
      endcase
   end
   assign next_phase = last_word ? result_port_pkg::PH_FIRST
                     : (phase == result_port_pkg::PH_FIRST
                        ? result_port_pkg::PH_SECOND
                        : result_port_pkg::PH_THIRD);
   assign pop = rd_rise && last_word && sel == `SEL_FIFO;

   always_ff @(posedge core_clk)
   begin
      if (!rstn || any_reset)
      begin
         phase    <= result_port_pkg::PH_FIRST;
         cyc_chan <= '0;
      end
      else if (rd_rise)
      begin
         phase <= next_phase;
         if (last_word && sel == `SEL_CYCLE)
            cyc_chan <= (cyc_chan == `LAST_DIRECT_CHAN) ? 3'h0
                                                       : cyc_chan + 3'h1;
      end
   end

   // Word selection for the current read
   logic [2:0]  out_chan;
   logic [15:0] out_data;
   logic        out_valid;
   logic [15:0] tag_word;
   logic [15:0] word;
   logic [7:0]  byte_val;

   assign out_chan  = (sel == `SEL_FIFO) ? head.chan
                    : (sel == `SEL_CYCLE) ? cyc_chan : sel;
   assign out_data  = (sel == `SEL_FIFO) ? (empty ? 16'h0000 : head.data)
                    : chan_reg[out_chan];
   assign out_valid = (sel == `SEL_FIFO) ? !empty : 1'b1;
   assign tag_word  = {`TAG_WORD_HEAD, out_valid, out_chan};
   assign byte_val  = (tag_on && phase == result_port_pkg::PH_FIRST)
                    ? {out_valid, out_chan, out_data[3:0]}
                    : ((phase == result_port_pkg::PH_FIRST) ||
                       (tag_on && phase == result_port_pkg::PH_SECOND))
                    ? out_data[7:0] : out_data[15:8];
   assign word      = s_byte ? {byte_val, byte_val}
                    : (tag_on && phase == result_port_pkg::PH_FIRST)
                    ? tag_word : out_data;

   // Drive the bus only while select and read strobe are low
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         parallel_data_bus_out <= '0;
         parallel_data_bus_oe  <= 1'b0;
         first_data_ready      <= 1'b0;
      end
      else
      begin
         parallel_data_bus_out <= word;
         parallel_data_bus_oe  <= rd_low;
         first_data_ready      <= (sel == `SEL_FIFO) && !empty;
      end
   end

   a_bus_only_reading:
      assert property (@(posedge core_clk) disable iff (!rstn)
      parallel_data_bus_oe |-> $past(rd_low))
      else $error("data bus driven without a read strobe");
   a_cycle_wraps:
      assert property (@(posedge core_clk) disable iff (!rstn)
      rd_rise && last_word && sel == `SEL_CYCLE && cyc_chan == 3'h5
      && !any_reset |=> cyc_chan == 3'h0)
      else $error("cycle pointer did not wrap after last channel");
   a_no_push_reading:
      assert property (@(posedge core_clk) disable iff (!rstn)
      rd_low && $past(rd_low) && !$past(any_reset) |-> $stable(head))
      else $error("result store changed while read strobe low");
   a_empty_zero:
      assert property (@(posedge core_clk) disable iff (!rstn)
      sel == `SEL_FIFO && empty && !tag_on && !s_byte |-> word == 16'h0000)
      else $error("empty store read was not zero");
   a_direct_untagged:
      assert property (@(posedge core_clk) disable iff (!rstn)
      rd_rise && direct && !s_byte |=> phase == result_port_pkg::PH_FIRST)
      else $error("tag phase used in direct mode");
   a_phase_reset:
      assert property (@(posedge core_clk)
      !rstn |=> phase == result_port_pkg::PH_FIRST && cyc_chan == 3'h0)
      else $error("phase or cycle pointer not cleared by reset");
   c_cycle_read: cover property (@(posedge core_clk) disable iff (!rstn)
      rd_rise && sel == `SEL_CYCLE);
   c_fifo_pop: cover property (@(posedge core_clk) disable iff (!rstn)
      pop);
   c_byte_tag: cover property (@(posedge core_clk) disable iff (!rstn)
      rd_rise && tag_on && s_byte && phase == result_port_pkg::PH_THIRD);
endmodule // result_read_port

// file: verification/host_bus_model.sv
/*
 * Host side of the parallel read-out bus: reads and control word writes.
 * Assumes a device that drives the bus only while selected and reading.
 */
`timescale 1ns/1ps
module host_bus_model
(
   input  wire logic        core_clk,
   input  wire logic [15:0] dev_out,
   input  wire logic        dev_oe,
   output logic             cs_n,
   output logic             rd_n,
   output logic             wr_n,
   output logic [15:0]      bus
);
   logic        drv = 1'b0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] last = 16'h0000;

   // Bus level: device, host, else a pattern that changes every cycle
   assign bus = dev_oe ? dev_out : (drv ? wdata : ~last);
   always_ff @(posedge core_clk) last <= bus;

   // Strobes idle high
   initial
   begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
   end

   // Select and read, take the word once the device drives it
   task automatic rd_start(output logic [15:0] d);
      int n;
      n = 0;
      @(posedge core_clk) #1;
      cs_n = 1'b0;
      rd_n = 1'b0;
      while (dev_oe !== 1'b1 && n < 20)
      begin
         @(posedge core_clk) #1;
         n++;
      end
      d = bus;
   endtask

   // Release and keep the strobe high long enough for the next read
   task automatic rd_end();
      @(posedge core_clk) #1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (5) @(posedge core_clk);
   endtask

   // Control word on the low byte, taken when the write strobe rises
   task automatic wr_word(input logic [7:0] w);
      @(posedge core_clk) #1;
      wdata = {8'h00, w};
      drv = 1'b1;
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (4) @(posedge core_clk);
      #1 wr_n = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 cs_n = 1'b1;
      drv = 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
endmodule // host_bus_model

// file: verification/test_adc_result_read_port.sv
/*
 * Self-checking bench of the result read-out port with a host model.
 * Assumes the design files and package compile ahead of this file.
 */
`timescale 1ns/1ps
module test_adc_result_read_port;
   logic        core_clk, rstn, tag_en, byte_mode, reset_pin;
   logic        cs_n, rd_n, wr_n, bus_oe, soft_reset, fdr;
   logic [2:0]  sel, holds;
   logic [5:0]  result_valid;
   logic [15:0] bus, bus_out, d;
   logic [95:0] result_data;
   int          errors, check_count, cycles;
   int          cnt [4];

   result_read_port dut (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .chan_sel_bit0(sel[0]),
      .chan_sel_bit1(sel[1]), .chan_sel_bit2(sel[2]), .tag_en(tag_en),
      .byte_mode(byte_mode), .reset_pin(reset_pin),
      .parallel_data_bus_in(bus), .result_valid(result_valid),
      .result_data(result_data), .parallel_data_bus_out(bus_out),
      .parallel_data_bus_oe(bus_oe), .soft_reset(soft_reset),
      .sample_hold_pair_first(holds[2]), .sample_hold_pair_second(holds[1]),
      .sample_hold_pair_third(holds[0]), .first_data_ready(fdr));

   host_bus_model host (.core_clk(core_clk), .dev_out(bus_out),
      .dev_oe(bus_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .bus(bus));

   // Clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Pulse counters for hold commands and soft reset, and the timeout
   always @(posedge core_clk)
   begin
      for (int i = 0; i < 3; i++) cnt[i] += int'(holds[i] === 1'b1);
      cnt[3] += int'(soft_reset === 1'b1);
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         wrap_up();
      end
   end

   function automatic logic [15:0] val(input int c);
      return 16'h5A00 + 16'(c) * 16'h0123;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset();
      @(posedge core_clk) #1 rstn = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 rstn = 1'b1;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic set_mode(input logic [2:0] s, input logic t, input logic b);
      @(posedge core_clk) #1;
      sel = s;
      tag_en = t;
      byte_mode = b;
   endtask

   task automatic push(input int c, input logic [15:0] v);
      @(posedge core_clk) #1;
      result_data[16*c +: 16] = v;
      result_valid[c] = 1'b1;
      @(posedge core_clk) #1 result_valid = 6'h00;
      repeat (3) @(posedge core_clk);
   endtask

   // One whole read; the bus must be released afterwards
   task automatic rd(output logic [15:0] w);
      host.rd_start(w);
      host.rd_end();
      check({15'h0000, bus_oe}, 16'h0000);
   endtask

   task automatic load_all();
      for (int c = 0; c < 6; c++) push(c, val(c));
   endtask

   task automatic t_direct();
      do_reset();
      load_all();
      for (int c = 0; c < 6; c++)
      begin
         set_mode(3'(c), 1'b1, 1'b0);
         rd(d);
         check(d, val(c));
      end
      set_mode(3'h3, 1'b1, 1'b1);
      rd(d);
      check({8'h00, d[7:0]}, val(3) & 16'h00FF);
      rd(d);
      check({8'h00, d[7:0]}, val(3) >> 8);
      $display("direct mode test done");
   endtask

   task automatic t_cycle();
      do_reset();
      set_mode(3'h6, 1'b0, 1'b0);
      load_all();
      for (int i = 0; i < 7; i++)
      begin
         rd(d);
         check(d, val(i % 6));
      end
      $display("cycle mode test done");
   endtask

   task automatic t_tagged();
      do_reset();
      set_mode(3'h7, 1'b1, 1'b0);
      push(4, val(4));
      push(1, val(1));
      rd(d);
      check(d, 16'h800C);
      rd(d);
      check(d, val(4));
      set_mode(3'h7, 1'b1, 1'b1);
      rd(d);
      check({8'h00, d[7:0]}, 16'h0090 | (val(1) & 16'h000F));
      rd(d);
      check({8'h00, d[7:0]}, val(1) & 16'h00FF);
      rd(d);
      check({8'h00, d[7:0]}, val(1) >> 8);
      $display("tagged read test done");
   endtask

   task automatic t_fifo();
      set_mode(3'h7, 1'b0, 1'b0);
      push(1, val(1));
      do_reset();
      rd(d);
      check(d, 16'h0000);
      push(2, val(2));
      push(0, val(0));
      push(5, val(5));
      check({15'h0000, fdr}, 16'h0001);
      rd(d);
      check(d, val(2));
      rd(d);
      check(d, val(0));
      rd(d);
      check(d, val(5));
      host.rd_start(d);
      push(3, val(3));
      check({15'h0000, fdr}, 16'h0000);
      host.rd_end();
      check(d, 16'h0000);
      rd(d);
      check(d, val(3));
      $display("store order test done");
   endtask

   task automatic t_overflow();
      do_reset();
      set_mode(3'h7, 1'b0, 1'b0);
      for (int k = 0; k < 19; k++) push(k % 6, 16'h1000 + 16'(k));
      for (int k = 1; k < 19; k++)
      begin
         rd(d);
         check(d, 16'h1000 + 16'(k));
      end
      rd(d);
      check(d, 16'h0000);
      $display("store overflow test done");
   endtask

   task automatic t_control();
      do_reset();
      set_mode(3'h0, 1'b0, 1'b0);
      load_all();
      host.wr_word(8'h8E);
      rd(d);
      check(d & 16'hFFF7, 16'h8000);
      rd(d);
      check(d, val(0));
      host.wr_word(8'h80);
      rd(d);
      check(d, val(0));
      for (int i = 0; i < 4; i++) cnt[i] = 0;
      host.wr_word(8'h07);
      for (int i = 0; i < 3; i++) check(16'(cnt[i]), 16'h0001);
      host.wr_word(8'h08);
      check(16'(cnt[3]), 16'h0001);
      @(posedge core_clk) #1 reset_pin = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 reset_pin = 1'b0;
      repeat (4) @(posedge core_clk);
      check(16'(cnt[3] > 1), 16'h0001);
      $display("control word test done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      rstn = 1'b0;
      sel = 3'h0;
      tag_en = 1'b0;
      byte_mode = 1'b0;
      reset_pin = 1'b0;
      result_valid = 6'h00;
      result_data = '0;
      t_direct();
      t_cycle();
      t_tagged();
      t_fifo();
      t_overflow();
      t_control();
      wrap_up();
   end
endmodule // test_adc_result_read_port
